// file: hdl/lad_formatter.sv
// Ladder converter code formatter with its APB register slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "lad_consts.svh"
////////////////////////////////////////////////////////////////////////////
// What this block does
// - Drive a 10-bit unsigned ladder code, zero lowest, all ones highest.
// - Full scale: inverted hold bit 7, hold bits 6..0, control bits 5..4.
// - Half scale: inverted hold bit 7, hold 7..0, control bit 5 only.
// - Control bit 3 high picks half scale, low picks full scale.
// - Full scale acts as 10-bit signed sample, zero gives code 200H.
// - Half scale acts as 9-bit signed sample, codes 100H to 2FFH.
// - Control low six bits change only on writes with bit 7 zero.
////////////////////////////////////////////////////////////////////////////
module lad_formatter (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Ladder input of the analog stage
	output logic [9:0] ladder_code
);
	lad_pkg::lad_apb_e st_ff;
	lad_pkg::lad_apb_e nxt_st;
	logic [5:0] ctl_ff;
	lad_pkg::lad_byte_t hold_ff;
	lad_pkg::lad_byte_t pace_ff;
	lad_pkg::lad_byte_t pace_cnt_ff;
	lad_pkg::lad_code_t ladder_code_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [9:0] word_index;
	logic hit_ctl;
	logic hit_hold;
	logic hit_pace;
	logic hit_stat;
	logic mapped;
	logic access;
	logic commit;
	logic wr_lane;
	logic ctl_accept;
	logic wants_push;
	logic stall;
	logic tick;
	logic pop;
	logic [5:0] new_ctl;
	lad_pkg::lad_byte_t new_hold;
	logic [31:0] rd_value;
	logic [`LAD_FIFO_AW:0] fifo_level;

	lad_stream_if #(.W(`LAD_CODE_W)) fill_if ();
	lad_stream_if #(.W(`LAD_CODE_W)) drain_if ();

	////////////////////////////////////////////////////////////////////////
	// Sign and mode mapping from sample to ladder code
	function automatic lad_pkg::lad_code_t ladder_map(
		input lad_pkg::lad_byte_t h,
		input logic [5:0] c
	);
		lad_pkg::lad_code_t code;
		if (c[`LAD_CTL_HALF]) begin
			// Sign extended nine bit sample, offset by 200H
			code = {~h[7], h, c[`LAD_CTL_BIT_ONE]};
		end else begin
			// Ten bit sample, sign flipped gives offset binary
			code = {~h[7], h[6:0], c[5:4]};
		end
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Address decode on word index
	assign word_index = paddr[11:2];
	assign hit_ctl = (word_index == `LAD_CTL_INDEX);
	assign hit_hold = (word_index == `LAD_HOLD_INDEX);
	assign hit_pace = (word_index == `LAD_PACE_INDEX);
	assign hit_stat = (word_index == `LAD_STAT_INDEX);
	assign mapped = hit_ctl | hit_hold | hit_pace | hit_stat;

	// Transfer phases and write qualifiers
	assign access = psel & penable;
	assign commit = access & pready_ff;
	assign wr_lane = pwrite & pstrb[0];
	assign ctl_accept = wr_lane & hit_ctl & ~pwdata[`LAD_CTL_GUARD];
	assign wants_push = (wr_lane & hit_hold) | ctl_accept;
	// A code write waits while the buffer is full
	assign stall = wants_push & ~fill_if.ready;

	// Values the registers take if this write commits
	assign new_ctl = ctl_accept ? pwdata[5:0] : ctl_ff;
	assign new_hold = (wr_lane & hit_hold) ? pwdata[7:0] : hold_ff;

	// Read data mux, unused bits read zero
	always_comb begin
		rd_value = 32'h0000_0000;
		if (hit_ctl) begin
			rd_value[5:0] = ctl_ff;
		end else if (hit_hold) begin
			rd_value[7:0] = hold_ff;
		end else if (hit_pace) begin
			rd_value[7:0] = pace_ff;
		end else if (hit_stat) begin
			rd_value[9:0] = ladder_code_ff;
			rd_value[`LAD_STAT_EMPTY] = ~drain_if.valid;
			rd_value[`LAD_STAT_FULL] = ~fill_if.ready;
			rd_value[`LAD_STAT_LEVEL_LSB +: 6] = fifo_level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave state, one wait state, more while a code write stalls on a full buffer, then a single ready cycle
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			lad_pkg::lad_st_wait: begin
				if (access && !stall) begin
					nxt_st = lad_pkg::lad_st_ack;
				end
			end
			lad_pkg::lad_st_ack: begin
				nxt_st = lad_pkg::lad_st_wait;
			end
			default: begin
				nxt_st = lad_pkg::lad_st_wait;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_ff <= lad_pkg::lad_st_wait;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Answer registers, captured as ready rises
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= (nxt_st == lad_pkg::lad_st_ack);
			if (st_ff == lad_pkg::lad_st_wait && nxt_st == lad_pkg::lad_st_ack) begin
				pslverr_ff <= ~mapped;
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_value;
			end else if (st_ff == lad_pkg::lad_st_ack) begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog control low bits, guarded by bit 7 of the written value
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_ff <= `LAD_CTL_RESET;
		end else if (commit && ctl_accept) begin
			ctl_ff <= pwdata[5:0];
		end
	end

	// Converter hold value, reset to the idle code source
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hold_ff <= `LAD_HOLD_RESET;
		end else if (commit && wr_lane && hit_hold) begin
			hold_ff <= pwdata[7:0];
		end
	end

	// Drain pacing divider, zero drains at once
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pace_ff <= `LAD_PACE_RESET;
		end else if (commit && wr_lane && hit_pace) begin
			pace_ff <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Each accepted code write pushes the freshly mapped code
	assign fill_if.valid = commit & wants_push;
	assign fill_if.data = ladder_map(new_hold, new_ctl);

	lad_fifo #(
		.WIDTH(`LAD_CODE_W),
		.DEPTH(`LAD_FIFO_DEPTH),
		.AW(`LAD_FIFO_AW)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.fill(fill_if),
		.drain(drain_if),
		.level(fifo_level)
	);

	// Drain at the paced rate
	assign tick = (pace_ff == 8'h00) || (pace_cnt_ff >= pace_ff);
	assign drain_if.ready = tick;
	assign pop = drain_if.valid & tick;

	// Pacing counter restarts at each drained code
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pace_cnt_ff <= 8'h00;
		end else if (pop) begin
			pace_cnt_ff <= 8'h00;
		end else if (!tick) begin
			pace_cnt_ff <= pace_cnt_ff + 8'h01;
		end
	end

	// Ladder code register, holds between drained codes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ladder_code_ff <= `LAD_CODE_RESET;
		end else if (pop) begin
			ladder_code_ff <= drain_if.data;
		end
	end

	// Outputs straight from flip-flops
	assign ladder_code = ladder_code_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks on the design's own behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// A code write commits into an idle path
	sequence s_fresh_commit;
		commit && wants_push && !drain_if.valid && (pace_ff == 8'h00);
	endsequence

	// A guarded control write commits
	sequence s_guard_commit;
		commit && wr_lane && hit_ctl && pwdata[`LAD_CTL_GUARD];
	endsequence

	a_code_follows: assert property (
		s_fresh_commit |=> ##1 ladder_code_ff == $past(fill_if.data, 2))
		else $error("ladder code missed the write");

	a_code_holds: assert property (
		!pop |=> $stable(ladder_code_ff))
		else $error("ladder code moved without a drain");

	a_full_map: assert property (
		fill_if.valid && !new_ctl[`LAD_CTL_HALF] |->
		fill_if.data == {~new_hold[7], new_hold[6:0], new_ctl[5:4]})
		else $error("full scale mapping wrong");

	a_half_map: assert property (
		fill_if.valid && new_ctl[`LAD_CTL_HALF] |->
		fill_if.data == {~new_hold[7], new_hold, new_ctl[5]})
		else $error("half scale mapping wrong");

	a_half_range: assert property (
		fill_if.valid && new_ctl[`LAD_CTL_HALF] |->
		fill_if.data >= 10'h100 && fill_if.data <= 10'h2ff)
		else $error("half scale code out of range");

	a_zero_mid: assert property (
		fill_if.valid && new_hold == 8'h00 && new_ctl[5:4] == 2'b00 |->
		fill_if.data == 10'h200)
		else $error("zero sample not at midscale");

	a_guard_blocks: assert property (
		s_guard_commit |=> $stable(ctl_ff))
		else $error("guarded write changed control bits");

	a_guard_accepts: assert property (
		commit && ctl_accept |=> ctl_ff == $past(pwdata[5:0]))
		else $error("control write was lost");

	a_ready_single: assert property (
		pready_ff |=> !pready_ff)
		else $error("ready held over two cycles");

	a_full_stalls: assert property (
		access && !pready_ff && stall |=> !pready_ff)
		else $error("code write answered while buffer full");

	a_unmapped_err: assert property (
		access && !pready_ff && !stall && !mapped |=> pready_ff && pslverr_ff)
		else $error("unmapped access not flagged");

	a_lowest_idle: assert property (
		pop && drain_if.data == 10'h000 |=> ladder_code_ff == 10'h000)
		else $error("lowest code not driven");

	// Full scale code is the signed sample plus midscale
	a_full_signed: assert property (
		fill_if.valid && !new_ctl[`LAD_CTL_HALF] |->
		fill_if.data == 10'({new_hold, new_ctl[5:4]} + 10'h200))
		else $error("full scale sample not offset to midscale");

	// Half scale code is the sign extended sample plus midscale
	a_half_signed: assert property (
		fill_if.valid && new_ctl[`LAD_CTL_HALF] |->
		fill_if.data == 10'({new_hold[7], new_hold, new_ctl[5]} + 10'h200))
		else $error("half scale sample not offset to midscale");

	// A request with room in the buffer is answered after one wait
	a_ready_wait: assert property (
		access && !pready_ff && !stall |=> pready_ff)
		else $error("ready missing after the wait state");

	// Writes answer with zero read data
	a_write_zero: assert property (
		pready_ff && pwrite |-> prdata_ff == 32'h0000_0000)
		else $error("write answered with read data");

	// A guarded control write pushes no code
	a_guard_no_push: assert property (
		s_guard_commit |-> !fill_if.valid)
		else $error("guarded write pushed a code");

	// A hold write lands at its committing edge
	a_hold_write: assert property (
		commit && wr_lane && hit_hold |=> hold_ff == $past(pwdata[7:0]))
		else $error("hold write was lost");

	// A write with lane zero off pushes nothing
	a_strobe_off: assert property (
		commit && pwrite && !pstrb[0] |-> !fill_if.valid)
		else $error("write without lane zero pushed a code");

	// A full buffer refuses further codes
	a_full_flag: assert property (
		fifo_level == 6'h20 |-> !fill_if.ready)
		else $error("full buffer still ready");

	// The buffer never holds more than its depth
	a_level_bound: assert property (
		fifo_level <= 6'h20)
		else $error("buffer level above depth");
endmodule

// file: hdl/lad_consts.svh
// Offsets, field positions, reset values and sizes of the ladder formatter
`ifndef LAD_CONSTS_SVH
`define LAD_CONSTS_SVH

// Register word indices, byte address is four times the index
`define LAD_CTL_INDEX 10'h0ef
`define LAD_HOLD_INDEX 10'h0fa
`define LAD_PACE_INDEX 10'h0f0
`define LAD_STAT_INDEX 10'h0f1

// Analog control field positions
`define LAD_CTL_GUARD 7
`define LAD_CTL_BIT_ONE 5
`define LAD_CTL_BIT_ZERO 4
`define LAD_CTL_HALF 3
`define LAD_CTL_LOW_MSB 5

// Hold value sign position
`define LAD_HOLD_SIGN 7

// Reset values
`define LAD_CTL_RESET 6'h00
`define LAD_HOLD_RESET 8'h80
`define LAD_PACE_RESET 8'h00
`define LAD_CODE_RESET 10'h000

// Status register field positions
`define LAD_STAT_EMPTY 16
`define LAD_STAT_FULL 17
`define LAD_STAT_LEVEL_LSB 24

// Sample buffer shape
`define LAD_CODE_W 10
`define LAD_FIFO_DEPTH 32
`define LAD_FIFO_AW 5

`endif

// file: hdl/lad_pkg.sv
// Types shared by the ladder formatter modules
package lad_pkg;
	// One ladder code word
	typedef logic [9:0] lad_code_t;
	// One register byte
	typedef logic [7:0] lad_byte_t;
	// Bus slave states
	typedef enum logic [1:0] {
		lad_st_wait = 2'b00,
		lad_st_ack = 2'b01
	} lad_apb_e;
endpackage

// file: hdl/lad_stream_if.sv
// Valid and ready stream between the formatter and its sample buffer
`timescale 1ns/1ps
interface lad_stream_if #(parameter int W = 10) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	// Producer end
	modport tx (output data, output valid, input ready);
	// Consumer end
	modport rx (input data, input valid, output ready);
endinterface

// file: hdl/lad_fifo.sv
// Sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module lad_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Filling side
	lad_stream_if.rx fill,
	// Draining side
	lad_stream_if.tx drain,
	// Words held
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_ff;
	logic [AW:0] rd_ptr_ff;
	logic full;
	logic empty;
	logic do_push;
	logic do_pop;

	////////////////////////////////////////////////////////////////////////
	// Flags from pointers with one wrap bit
	assign level = wr_ptr_ff - rd_ptr_ff;
	assign full = (level == (AW+1)'(DEPTH));
	assign empty = (level == '0);
	assign fill.ready = ~full;
	assign drain.valid = ~empty;
	assign drain.data = mem[rd_ptr_ff[AW-1:0]];
	assign do_push = fill.valid & ~full;
	assign do_pop = drain.ready & ~empty;

	// Storage, no reset needed on data
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wr_ptr_ff[AW-1:0]] <= fill.data;
		end
	end

	// Write pointer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
		end else if (do_push) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_ptr_ff <= '0;
		end else if (do_pop) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end
endmodule

// file: testbench/lad_ladder_stage.sv
// Behavioural resistor ladder output stage seen by the formatter
`timescale 1ns/1ps
module lad_ladder_stage (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Code from the formatter
	input wire logic [9:0] code,
	// Output level in millivolts at a 3000 mV supply
	output logic [11:0] level_mv_ff
);
	// Unsigned code, zero lowest, all ones one step under supply
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			level_mv_ff <= 12'h000;
		end else begin
			level_mv_ff <= 12'((32'(code) * 3000) >> 10);
		end
	end
endmodule

// file: testbench/test_ladder_dac_code_formatter.sv
// Self-checking bench of the ladder code formatter
`timescale 1ns/1ps
`include "lad_consts.svh"
module test_ladder_dac_code_formatter;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr, lvl;
	logic [31:0] pwdata, prdata, rd, lfsr, waited;
	logic [3:0] pstrb;
	logic [9:0] ladder_code, exp_code;
	logic [7:0] hold, ctl, dh, dc;
	logic [7:0] cor [4] = '{8'h80, 8'h7f, 8'h00, 8'hff};
	int miscompares, num_checks;
	localparam logic [11:0] adr_ctl = {`LAD_CTL_INDEX, 2'b00};
	localparam logic [11:0] adr_hold = {`LAD_HOLD_INDEX, 2'b00};
	localparam logic [11:0] adr_pace = {`LAD_PACE_INDEX, 2'b00};
	localparam logic [11:0] adr_stat = {`LAD_STAT_INDEX, 2'b00};

	// Design and far side
	lad_formatter i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ladder_code(ladder_code));
	lad_ladder_stage i_stage (.clock(clock), .rst_n(rst_n),
		.code(ladder_code), .level_mv_ff(lvl));

	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Next random word
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Signed sample offset to midscale
	function automatic logic [9:0] fmt(input logic [7:0] h, c);
		if (c[`LAD_CTL_HALF]) return {h[7], h, c[5]} ^ 10'h200;
		return {h, c[5:4]} ^ 10'h200;
	endfunction

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Counts and verdict
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// One APB transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		waited = 0;
		do begin
			@(posedge clock);
			waited++;
		end while (pready !== 1'b1 && waited < 5000);
		check("apb answer", pready, 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	// Register write with code timing check
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		if (a == adr_ctl && !d[7]) ctl = d;
		if (a == adr_hold) hold = d;
		apb(1'b1, a, {24'h00_0000, d});
		check("code held", ladder_code, exp_code);
		exp_code = fmt(hold, ctl);
		@(posedge clock);
		check("ladder code", ladder_code, exp_code);
	endtask

	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		lfsr = 32'h0000_dc42;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("reset code", ladder_code, 10'h000);
		apb(1'b0, adr_hold, 32'h0);
		check("hold reset", rd, 32'h0000_0080);
		hold = 8'h80;
		ctl = 8'h00;
		exp_code = 10'h000;
		// Corner samples first, then random ones in both modes
		for (int i = 0; i < 48; i++) begin
			lfsr = rnd(lfsr);
			dh = (i < 16) ? cor[i % 4] : lfsr[7:0];
			dc = (i < 16) ? {2'b00, {2{i[2]}}, i[3], lfsr[10:8]}
				: {2'b00, lfsr[13:8]};
			wr(adr_ctl, dc);
			wr(adr_hold, dh);
			apb(1'b0, adr_ctl, 32'h0);
			check("ctl read", rd, {26'h0, ctl[5:0]});
		end
		// Guarded control write changes nothing
		apb(1'b1, adr_ctl, {24'h0, 8'h80 | (~ctl & 8'h3f)});
		repeat (2) @(posedge clock);
		check("guard code", ladder_code, exp_code);
		apb(1'b0, adr_ctl, 32'h0);
		check("guard ctl", rd, {26'h0, ctl[5:0]});
		// Unmapped place and read-only status
		apb(1'b0, 12'h000, 32'h0);
		check("unmapped err", er, 1'b1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, adr_stat, 32'hffff_ffff);
		check("status write err", er, 1'b0);
		apb(1'b0, adr_stat, 32'h0);
		check("status code", rd[9:0], exp_code);
		// Software idles the converter
		wr(adr_ctl, 8'h00);
		wr(adr_hold, 8'h80);
		check("idle code", ladder_code, 10'h000);
		// Write with lane zero off changes nothing
		pstrb <= 4'he;
		apb(1'b1, adr_hold, 32'h0000_0055);
		pstrb <= 4'hf;
		apb(1'b0, adr_hold, 32'h0);
		check("strobe off hold", rd, 32'h0000_0080);
		check("strobe off code", ladder_code, 10'h000);
		check("idle level", lvl, 12'h000);
		// Slow drain: fill the buffer until it stalls the bus
		apb(1'b1, adr_pace, 32'h0000_00ff);
		apb(1'b0, adr_pace, 32'h0);
		check("pace read", rd, 32'h0000_00ff);
		for (int i = 0; i < 34; i++) begin
			lfsr = rnd(lfsr);
			hold = lfsr[7:0];
			apb(1'b1, adr_hold, {24'h0, hold});
		end
		check("stalled", waited > 100, 1'b1);
		apb(1'b0, adr_stat, 32'h0);
		check("full", rd[`LAD_STAT_FULL], 1'b1);
		check("level", rd[`LAD_STAT_LEVEL_LSB +: 6], 6'h20);
		apb(1'b1, adr_pace, 32'h0);
		for (int n = 0; n < 40 && rd[`LAD_STAT_EMPTY] !== 1'b1; n++)
			apb(1'b0, adr_stat, 32'h0);
		check("drained", rd[`LAD_STAT_EMPTY], 1'b1);
		check("last code", ladder_code, fmt(hold, ctl));
		print_verdict();
	end

	// Watchdog against a hang
	initial begin
		repeat (30000) @(posedge clock);
		miscompares++;
		print_verdict();
	end
endmodule
